// *** design/rtc_port_pkg.sv ***
// Summary of operation
// - write strobe high with register select low is a read cycle.
// - four address lines pick one of sixteen clock registers.
// - read data timed from the later of select low or output enable low.
// - read data valid within 70 ns (85 ns slow grade) of stable address.
// - read data valid within 70 ns (85 ns slow grade) of select falling.
// - data lines float within 20 ns of output enable or select rising; the port takes up to 24 ns at an 8 ns clock.
// - old read data holds at least 5 ns after an address change.
// - external select low steers the access to the external RAM.
// - write strobe and select both low after stable address is a write.
// - write spans later falling edge to earlier rising edge of strobe, select.
// - output enable high in writes; falling strobe floats outputs in 20 ns; the port takes up to 24 ns at an 8 ns clock.
// - outputs stay floating at least 5 ns after write strobe rises.
// - write with select low stores the data byte in the addressed register.
// - write with external select low, register select high goes to RAM.
// - bank enables follow the high address line while external select low.
// - register select high deselects; data lines float.
package rtc_port_pkg;
   // ************************************************************
   // geometry
   // ************************************************************
   localparam int addr_width = 4;
   localparam int data_width = 8;
   localparam int reg_count = 16;
   localparam logic [7:0] reg_reset_value = 8'h00;
   // ************************************************************
   // timing, faster grade
   // ************************************************************
   localparam int clk_period_ns = 8;
   localparam int read_access_ns = 70;
   localparam int oe_access_ns = 25;
   localparam int float_ns = 20;
   localparam int hold_min_ns = 5;
   localparam int read_access_cycles = read_access_ns / clk_period_ns;
   localparam int oe_access_cycles = oe_access_ns / clk_period_ns;
   localparam int float_cycles = float_ns / clk_period_ns;
   localparam int hold_min_cycles = (hold_min_ns + clk_period_ns - 1) / clk_period_ns;
endpackage : rtc_port_pkg

// *** design/pin_sync.sv ***
`timescale 1ns/1ns
// two-stage synchroniser for a group of pin inputs
module pin_sync #(
   parameter int width = 1
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [width-1:0] pin_in,
   output logic [width-1:0] pin_out
);
   logic [width-1:0] meta_reg;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         meta_reg <= '0;
         pin_out <= '0;
      end else begin
         meta_reg <= pin_in;
         pin_out <= meta_reg;
      end
   end
endmodule : pin_sync

// *** design/rtc_async_bus_port.sv ***
`timescale 1ns/1ns
module rtc_async_bus_port (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [3:0] reg_addr_lines,
   input wire logic reg_select_n,
   input wire logic output_enable_n,
   input wire logic write_strobe_n,
   input wire logic ext_ram_select_n,
   input wire logic [7:0] byte_data_lines_in,
   output logic [7:0] byte_data_lines_out,
   output logic [7:0] byte_data_lines_oe,
   output logic ram_bank_one_enable_n,
   output logic ram_bank_two_enable_n
);
   // ************************************************************
   // pin synchronisers
   // ************************************************************
   // selects reset high (idle) so no access is seen out of reset
   logic [3:0] addr_s;
   logic [7:0] din_s;
   logic [3:0] ctl_s;
   logic [3:0] ctl_raw;
   logic sel_n;
   logic oe_n;
   logic wr_n;
   logic ext_n;

   assign ctl_raw = ~{reg_select_n, output_enable_n, write_strobe_n, ext_ram_select_n};

   pin_sync #(.width(4)) u_addr_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .pin_in(reg_addr_lines),
      .pin_out(addr_s)
   );
   pin_sync #(.width(8)) u_data_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .pin_in(byte_data_lines_in),
      .pin_out(din_s)
   );
   pin_sync #(.width(4)) u_ctl_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .pin_in(ctl_raw),
      .pin_out(ctl_s)
   );

   assign sel_n = ~ctl_s[3];
   assign oe_n = ~ctl_s[2];
   assign wr_n = ~ctl_s[1];
   assign ext_n = ~ctl_s[0];

   // ************************************************************
   // cycle decode
   // ************************************************************
   logic read_cycle;
   logic write_cycle;
   logic drive_ok;
   logic write_end;
   logic wr_active_reg;
   logic [3:0] wr_addr_reg;
   logic [7:0] wr_data_reg;

   assign read_cycle = wr_n && !sel_n;
   assign write_cycle = !wr_n && !sel_n;
   // write ends at first rising strobe or select
   assign write_end = wr_active_reg && !write_cycle;
   // drive only in a read with output enable low
   assign drive_ok = read_cycle && !oe_n;

   // ************************************************************
   // register array
   // ************************************************************
   logic [7:0] regs_reg [rtc_port_pkg::reg_count];

   // track write span, latch last data before end
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         wr_active_reg <= 1'b0;
         wr_addr_reg <= 4'h0;
         wr_data_reg <= 8'h00;
      end else begin
         wr_active_reg <= write_cycle;
         if (write_cycle) begin
            wr_addr_reg <= addr_s;
            wr_data_reg <= din_s;
         end
      end
   end

   // store byte at write end; one register per address
   genvar gi;
   generate
      for (gi = 0; gi < rtc_port_pkg::reg_count; gi++) begin : g_reg
         always_ff @(posedge sys_clk) begin
            if (!reset_n) begin
               regs_reg[gi] <= rtc_port_pkg::reg_reset_value;
            end else if (write_end && wr_addr_reg == 4'(gi)) begin
               regs_reg[gi] <= wr_data_reg;
            end
         end
      end
   endgenerate

   // ************************************************************
   // read data path
   // ************************************************************
   // synchronised pins plus one output stage stay well inside 70/25/20 ns
   // only in a faster clock; at 8 ns the three stages take up to 24 ns
   logic [7:0] rd_sel;
   assign rd_sel = regs_reg[addr_s];

   // output driven one cycle after decode
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         byte_data_lines_out <= 8'h00;
         byte_data_lines_oe <= 8'h00;
      end else begin
         byte_data_lines_out <= drive_ok ? rd_sel : byte_data_lines_out;
         byte_data_lines_oe <= {8{drive_ok}};
      end
   end

   // ************************************************************
   // external ram bank enables
   // ************************************************************
   logic bank_one_next;
   logic bank_two_next;
   // high address bit picks bank while external select low
   assign bank_one_next = !(!ext_n && !addr_s[3]);
   assign bank_two_next = !(!ext_n && addr_s[3]);

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         ram_bank_one_enable_n <= 1'b1;
         ram_bank_two_enable_n <= 1'b1;
      end else begin
         ram_bank_one_enable_n <= bank_one_next;
         ram_bank_two_enable_n <= bank_two_next;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   sequence s_write_done;
      write_cycle ##1 !write_cycle;
   endsequence

   read_drive_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (read_cycle && !oe_n) |=> byte_data_lines_oe == 8'hff)
      else $error("read with output enable low not driven");
   reg_store_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_write_done |=> regs_reg[$past(wr_addr_reg)] == $past(wr_data_reg))
      else $error("written byte not stored");
   addr_select_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      drive_ok |=> byte_data_lines_out == $past(rd_sel))
      else $error("read data not from addressed register");
   deselect_float_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      sel_n |=> byte_data_lines_oe == 8'h00)
      else $error("data lines driven while deselected");
   write_float_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !wr_n |-> ##[1:2] byte_data_lines_oe == 8'h00)
      else $error("outputs not floated after write strobe");
   oe_high_float_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (read_cycle && oe_n) |=> byte_data_lines_oe == 8'h00)
      else $error("outputs driven with output enable high");
   bank_one_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (!ext_n && !addr_s[3]) |=> !ram_bank_one_enable_n && ram_bank_two_enable_n)
      else $error("bank one not selected");
   bank_idle_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      ext_n |=> ram_bank_one_enable_n && ram_bank_two_enable_n)
      else $error("bank enabled without external select");
   write_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
      write_cycle |=> wr_active_reg)
      else $error("write cycle not tracked");
endmodule : rtc_async_bus_port

// *** tb/sram_model.sv ***
`timescale 1ns/1ns
// ************************************************************
// external static ram stand-in
// ************************************************************
module sram_model (
   input wire logic sys_clk,
   input wire logic bank_one_n,
   input wire logic bank_two_n,
   input wire logic output_enable_n,
   input wire logic write_strobe_n,
   input wire logic [3:0] addr,
   input wire logic [7:0] data_in,
   output logic drive,
   output logic [7:0] data_out
);
   logic [7:0] mem [16];
   logic wr_reg;
   wire sel = !(bank_one_n && bank_two_n);
   assign drive = sel && !output_enable_n && write_strobe_n;
   assign data_out = mem[addr];
   // commit on the strobe rising, like a real part latching at write end
   always @(posedge sys_clk) begin
      wr_reg <= write_strobe_n;
      if (sel && write_strobe_n && !wr_reg) begin
         mem[addr] <= data_in;
      end
   end
endmodule : sram_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
// ************************************************************
// bench for the host bus port
// ************************************************************
module tb_top;
   logic sys_clk = 1'h0, reset_n = 1'h0, sel_n = 1'h1, oe_n = 1'h1, wr_n = 1'h1, ext_n = 1'h1;
   logic [3:0] addr = 4'h0;
   logic [7:0] host_q = 8'h00, dq_out, dq_oe, ram_q, exp_mem [16];
   logic bank1_n, bank2_n, ram_drv;
   // lines the port leaves undriven show the RAM byte while it drives, else host_q
   wire [7:0] dq = (dq_oe & dq_out) | (~dq_oe & (ram_drv ? ram_q : host_q));
   int fail_count = 0, tests_run = 0, cycles = 0;
   initial forever #4 sys_clk = ~sys_clk;
   rtc_async_bus_port i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr_lines(addr),
      .reg_select_n(sel_n), .output_enable_n(oe_n), .write_strobe_n(wr_n),
      .ext_ram_select_n(ext_n), .byte_data_lines_in(dq), .byte_data_lines_out(dq_out),
      .byte_data_lines_oe(dq_oe), .ram_bank_one_enable_n(bank1_n),
      .ram_bank_two_enable_n(bank2_n));
   sram_model i_ram (.sys_clk(sys_clk), .bank_one_n(bank1_n), .bank_two_n(bank2_n),
      .output_enable_n(oe_n), .write_strobe_n(wr_n), .addr(addr), .data_in(dq),
      .drive(ram_drv), .data_out(ram_q));
   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : tick
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up
   task automatic bus_read(input logic [3:0] a, input logic oe_val, input logic [7:0] exp);
      addr = a;
      oe_n = oe_val;
      sel_n = 1'h0;
      tick(4);
      check(dq_oe, oe_val ? 8'h00 : 8'hff);
      if (!oe_val) check(dq_out, exp);
      sel_n = 1'h1;
      oe_n = 1'h1;
      tick(4);
      check(dq_oe, 8'h00);
   endtask : bus_read
   // strobe held 7 cycles, covering pulse width, select width and address setup
   task automatic bus_write(input logic [3:0] a, input logic [7:0] d, input logic ext);
      addr = a;
      host_q = d;
      sel_n = ext;
      ext_n = !ext;
      wr_n = 1'h0;
      tick(7);
      check({6'h00, bank1_n, bank2_n}, {6'h00, ext ? {a[3], !a[3]} : 2'h3});
      wr_n = 1'h1;
      tick(2);
      // address and selects released only after the strobe
      sel_n = 1'h1;
      ext_n = 1'h1;
      host_q = ~d;
      tick(4);
   endtask : bus_write
   task automatic t_write_all;
      for (int i = 0; i < 16; i++) begin
         exp_mem[i] = 8'ha5 ^ (8'h11 * i[7:0]);
         bus_write(i[3:0], exp_mem[i], 1'h0);
      end
      for (int i = 0; i < 16; i++) bus_read(i[3:0], 1'h0, exp_mem[i]);
   endtask : t_write_all
   task automatic t_deselect;
      addr = 4'h3;
      host_q = 8'h5a;
      oe_n = 1'h0;
      wr_n = 1'h0;
      tick(6);
      check(dq_oe, 8'h00);
      oe_n = 1'h1;
      wr_n = 1'h1;
      tick(4);
      bus_read(4'h3, 1'h0, exp_mem[3]);
      bus_read(4'h3, 1'h1, 8'h00);
   endtask : t_deselect
   task automatic t_ext;
      bus_write(4'h5, 8'h3c, 1'h1);
      bus_write(4'hd, 8'hc3, 1'h1);
      bus_read(4'h5, 1'h0, exp_mem[5]);
      addr = 4'h5;
      ext_n = 1'h0;
      oe_n = 1'h0;
      tick(4);
      check(dq_oe, 8'h00);
      check(dq, 8'h3c);
      addr = 4'hd;
      tick(4);
      check(dq, 8'hc3);
      ext_n = 1'h1;
      oe_n = 1'h1;
      tick(4);
   endtask : t_ext
   task automatic t_wr_float;
      addr = 4'h6;
      sel_n = 1'h0;
      oe_n = 1'h0;
      tick(4);
      check(dq_oe, 8'hff);
      // a fresh byte, so that a lost write shows in the read-back
      exp_mem[6] = ~exp_mem[6];
      host_q = exp_mem[6];
      wr_n = 1'h0;
      tick(7);
      check(dq_oe, 8'h00);
      wr_n = 1'h1;
      tick(1);
      check(dq_oe, 8'h00);
      tick(3);
      check(dq_out, exp_mem[6]);
      sel_n = 1'h1;
      oe_n = 1'h1;
      tick(4);
   endtask : t_wr_float
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         $display("unexpected at %0t: run did not finish in time", $time);
         wrap_up();
      end
   end
   initial begin
      tick(8);
      reset_n = 1'h1;
      tick(2);
      for (int i = 0; i < 16; i++) bus_read(i[3:0], 1'h0, 8'h00);
      t_write_all();
      t_deselect();
      t_ext();
      t_wr_float();
      wrap_up();
   end
endmodule : tb_top
